//--- common/asaf_pkg.sv
// package for the status alias block: register offsets, field positions, modes
// assumes one clock domain and a host access port in the register clock domain
package asaf_pkg;
    localparam logic [7:0] STATUS_ALIAS_ADDR = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ADDR_ZERO = 8'h00;
    localparam logic [7:0] ADDR_ONE = 8'h01;
    localparam logic [1:0] FIFO_MODE_OFF = 2'h0;
    localparam logic [1:0] FIFO_MODE_TRIGGER = 2'h3;
    localparam logic [5:0] FIFO_DEPTH = 6'h20;
    // sample status byte fields
    localparam int BIT_XYZ_OVER = 7;
    localparam int BIT_Z_OVER = 6;
    localparam int BIT_Y_OVER = 5;
    localparam int BIT_X_OVER = 4;
    localparam int BIT_XYZ_READY = 3;
    localparam int BIT_Z_READY = 2;
    localparam int BIT_Y_READY = 1;
    localparam int BIT_X_READY = 0;
    // fifo status byte fields
    localparam int BIT_FIFO_OVERFLOW = 7;
    localparam int BIT_FIFO_WATERMARK = 6;
    localparam int COUNT_MSB = 5;
    localparam int COUNT_LSB = 0;
    // axis index into three-bit vectors
    localparam int AXIS_X = 0;
    localparam int AXIS_Y = 1;
    localparam int AXIS_Z = 2;
endpackage : asaf_pkg

//--- logic/asaf_status.sv
// status alias logic at register address zero plus address pointer handling
// assumes host byte reads arrive as one-cycle strobes, synchronous to CLOCK;
// sample, fifo and high-byte read events come from neighbouring logic
//
// Summary of operation
// R1: address zero shows sample status when fifo mode is zero, else fifo status
// R2: burst read returns status then next data byte, any data width
// R3: combined overwrite sets when new sample overwrites any unread axis
// R4: combined overwrite clears once the high bytes of all unread axes were read
// R5: per-axis overwrite sets on unread overwrite, clears on its high-byte read
// R6: per-axis ready sets on acquisition, clears on its high-byte read
// R7: combined ready sets on any new data, clears after all high bytes read
// R8: fifo status carries six-bit sample count, zero empty, up to thirty-two
// R9: overflow flag stays set while the fifo remains overflowed
// R10: watermark flag stays set while count is at or above watermark
// R11: in trigger mode the watermark position shows a trigger event
// R12: reading fifo status clears fifo interrupt source; next sample re-arms it while overflowed, or at watermark (triggered in trigger mode)
// R13: byte layouts fixed; all bits reset to zero
// R14: address advances automatically only during burst reads
// R15: serial-bus stop resets address to zero; other port never resets it
module asaf_status
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // configuration
    input wire logic [1:0] FIFO_MODE,
    input wire logic [5:0] FIFO_WATERMARK,
    input wire logic SPI_SELECT,
    // acquisition events, one-cycle pulses per axis
    input wire logic [2:0] AXIS_ACQUIRED,
    // fifo state from the sample buffer
    input wire logic [5:0] FIFO_COUNT,
    input wire logic FIFO_OVERFLOWED,
    input wire logic FIFO_TRIGGERED,
    input wire logic FIFO_SAMPLE_IN,
    // host access
    input wire logic ADDR_LOAD,
    input wire logic [7:0] ADDR_VALUE,
    input wire logic READ_STROBE,
    input wire logic BURST,
    input wire logic STOP_SEEN,
    input wire logic [7:0] DATA_BYTE,
    input wire logic [2:0] HIGH_BYTE_READ,
    // outputs
    output logic [7:0] READ_DATA,
    output logic [7:0] READ_ADDR,
    output logic FIFO_INT_SOURCE
);
    logic [2:0] ready;
    logic [2:0] over;
    logic [2:0] pending;
    logic xyz_ready;
    logic xyz_over;
    logic int_src;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic [2:0] next_ready;
    logic [2:0] next_over;
    logic [2:0] next_pending;
    logic next_xyz_ready;
    logic next_xyz_over;
    logic next_int_src;
    logic [7:0] next_addr;
    logic [7:0] next_rdata;
    logic [7:0] status_byte;
    logic [7:0] fifo_byte;
    logic [7:0] sample_byte;
    logic status_read;

    // status byte builders
    function automatic logic [7:0] asaf_sample_byte(input logic [2:0] ov, input logic [2:0] rd,
        input logic cov, input logic crd);
        logic [7:0] b;
        b = asaf_pkg::RESET_BYTE;
        b[asaf_pkg::BIT_XYZ_OVER] = cov;
        b[asaf_pkg::BIT_Z_OVER] = ov[asaf_pkg::AXIS_Z];
        b[asaf_pkg::BIT_Y_OVER] = ov[asaf_pkg::AXIS_Y];
        b[asaf_pkg::BIT_X_OVER] = ov[asaf_pkg::AXIS_X];
        b[asaf_pkg::BIT_XYZ_READY] = crd;
        b[asaf_pkg::BIT_Z_READY] = rd[asaf_pkg::AXIS_Z];
        b[asaf_pkg::BIT_Y_READY] = rd[asaf_pkg::AXIS_Y];
        b[asaf_pkg::BIT_X_READY] = rd[asaf_pkg::AXIS_X];
        return b;
    endfunction : asaf_sample_byte

    // status bytes are live views so a read returns current state
    always_comb
    begin
        sample_byte = asaf_sample_byte(over, ready, xyz_over, xyz_ready); // R13
        fifo_byte = asaf_pkg::RESET_BYTE;
        fifo_byte[asaf_pkg::BIT_FIFO_OVERFLOW] = FIFO_OVERFLOWED; // R9
        if (FIFO_MODE == asaf_pkg::FIFO_MODE_TRIGGER)
        begin
            fifo_byte[asaf_pkg::BIT_FIFO_WATERMARK] = FIFO_TRIGGERED; // R11
        end
        else
        begin
            fifo_byte[asaf_pkg::BIT_FIFO_WATERMARK] = (FIFO_COUNT >= FIFO_WATERMARK); // R10
        end
        // count beyond depth is clamped, never reported past thirty-two
        fifo_byte[asaf_pkg::COUNT_MSB:asaf_pkg::COUNT_LSB] =
            (FIFO_COUNT > asaf_pkg::FIFO_DEPTH) ? asaf_pkg::FIFO_DEPTH : FIFO_COUNT; // R8
        if (FIFO_MODE == asaf_pkg::FIFO_MODE_OFF)
        begin
            status_byte = sample_byte; // R1
        end
        else
        begin
            status_byte = fifo_byte; // R1
        end
        status_read = READ_STROBE && (addr == asaf_pkg::STATUS_ALIAS_ADDR);
    end

    // data-ready and overwrite flags; a set in the clear cycle wins
    always_comb
    begin
        next_pending = pending;
        for (int i = 0; i < 3; i++)
        begin
            next_ready[i] = ready[i];
            next_over[i] = over[i];
            if (HIGH_BYTE_READ[i])
            begin
                next_ready[i] = 1'b0; // R6
                next_over[i] = 1'b0; // R5
                next_pending[i] = 1'b0;
            end
            if (AXIS_ACQUIRED[i])
            begin
                next_ready[i] = 1'b1; // R6
                next_pending[i] = 1'b1;
                if (pending[i])
                begin
                    next_over[i] = 1'b1; // R5
                end
            end
        end
        next_xyz_ready = xyz_ready;
        next_xyz_over = xyz_over;
        // combined flags clear when no axis is left unread
        if ((pending & ~HIGH_BYTE_READ) == 3'h0)
        begin
            next_xyz_ready = 1'b0; // R7
            next_xyz_over = 1'b0; // R4
        end
        if (AXIS_ACQUIRED != 3'h0)
        begin
            next_xyz_ready = 1'b1; // R7
        end
        if ((AXIS_ACQUIRED & pending) != 3'h0)
        begin
            next_xyz_over = 1'b1; // R3
        end
    end

    // fifo interrupt source: cleared by status read, re-armed by next sample while overflowed, or at watermark (triggered in trigger mode)
    always_comb
    begin
        next_int_src = int_src;
        if (status_read && (FIFO_MODE != asaf_pkg::FIFO_MODE_OFF))
        begin
            next_int_src = 1'b0; // R12
        end
        if (FIFO_SAMPLE_IN && (FIFO_OVERFLOWED || fifo_byte[asaf_pkg::BIT_FIFO_WATERMARK]))
        begin
            next_int_src = 1'b1; // R12
        end
    end

    // address pointer and read data
    always_comb
    begin
        next_addr = addr;
        next_rdata = rdata;
        if (READ_STROBE)
        begin
            next_rdata = (addr == asaf_pkg::STATUS_ALIAS_ADDR) ? status_byte : DATA_BYTE; // R2
            if (BURST)
            begin
                next_addr = addr + asaf_pkg::ADDR_ONE; // R14
            end
        end
        if (ADDR_LOAD)
        begin
            next_addr = ADDR_VALUE;
        end
        if (STOP_SEEN && !SPI_SELECT)
        begin
            next_addr = asaf_pkg::ADDR_ZERO; // R15
        end
    end

    // registers
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ready <= 3'h0; // R13
            over <= 3'h0;
            pending <= 3'h0;
            xyz_ready <= 1'b0;
            xyz_over <= 1'b0;
            int_src <= 1'b0;
            addr <= asaf_pkg::ADDR_ZERO;
            rdata <= asaf_pkg::RESET_BYTE;
        end
        else
        begin
            ready <= next_ready;
            over <= next_over;
            pending <= next_pending;
            xyz_ready <= next_xyz_ready;
            xyz_over <= next_xyz_over;
            int_src <= next_int_src;
            addr <= next_addr;
            rdata <= next_rdata;
        end
    end

    assign READ_DATA = rdata;
    assign READ_ADDR = addr;
    assign FIFO_INT_SOURCE = int_src;
endmodule : asaf_status

//--- testbench/asaf_host.sv
// host model: address loads, byte reads and stop conditions
// assumes the bench calls op right after a rising CLOCK edge
module asaf_host
(
    // clock
    input wire logic CLOCK,
    // host access strobes
    output logic ADDR_LOAD,
    output logic [7:0] ADDR_VALUE,
    output logic READ_STROBE,
    output logic BURST,
    output logic STOP_SEEN
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {ADDR_LOAD, ADDR_VALUE, READ_STROBE, BURST, STOP_SEEN} = 12'h000;
    // k = {load, read, stop}; idle edge after keeps one assignment per step
    task automatic op(input logic [2:0] k, input logic [7:0] a);
        {ADDR_LOAD, READ_STROBE, STOP_SEEN} <= k;
        ADDR_VALUE <= a;
        BURST <= a[0];
        @(posedge CLOCK);
        {ADDR_LOAD, READ_STROBE, STOP_SEEN} <= 3'h0;
        @(posedge CLOCK);
    endtask : op
endmodule : asaf_host

//--- testbench/asaf_status_asserts.sv
// checker for the status alias block, bound to asaf_status
// assumes read data lands one edge after the strobe is taken
module asaf_status_asserts
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // watched ports
    input wire logic [1:0] FIFO_MODE,
    input wire logic SPI_SELECT,
    input wire logic [2:0] AXIS_ACQUIRED,
    input wire logic [5:0] FIFO_COUNT,
    input wire logic FIFO_OVERFLOWED,
    input wire logic FIFO_TRIGGERED,
    input wire logic FIFO_SAMPLE_IN,
    input wire logic ADDR_LOAD,
    input wire logic READ_STROBE,
    input wire logic BURST,
    input wire logic STOP_SEEN,
    input wire logic [7:0] READ_DATA,
    input wire logic [7:0] READ_ADDR,
    input wire logic FIFO_INT_SOURCE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    // pointer moves only when no load or stop competes
    wire mv = !ADDR_LOAD && !STOP_SEEN;
    wire frd = READ_STROBE && READ_ADDR == 8'h00 && FIFO_MODE != 2'h0;
    sequence s_acq_read;
        AXIS_ACQUIRED[0] ##1 READ_STROBE && READ_ADDR == 8'h00 && FIFO_MODE == 2'h0;
    endsequence
    a_burst_step: assert property (READ_STROBE && BURST && mv
        |=> READ_ADDR == $past(READ_ADDR) + 8'h01) else $error("no burst step");
    a_single_hold: assert property (READ_STROBE && !BURST && mv
        |=> $stable(READ_ADDR)) else $error("single read moved pointer");
    a_stop_zero: assert property (STOP_SEEN && !SPI_SELECT
        |=> READ_ADDR == 8'h00) else $error("stop kept pointer");
    a_count_shown: assert property (frd && FIFO_COUNT <= 6'h20
        |=> READ_DATA[5:0] == $past(FIFO_COUNT)) else $error("bad count");
    a_ovf_shown: assert property (frd
        |=> READ_DATA[7] == $past(FIFO_OVERFLOWED)) else $error("bad overflow");
    a_trig_shown: assert property (frd && FIFO_MODE == 2'h3
        |=> READ_DATA[6] == $past(FIFO_TRIGGERED)) else $error("bad trigger");
    a_int_clear: assert property (frd && !FIFO_SAMPLE_IN
        |=> !FIFO_INT_SOURCE) else $error("source not cleared");
    a_ready_seen: assert property (s_acq_read
        |=> READ_DATA[0] && READ_DATA[3]) else $error("ready not shown");
endmodule : asaf_status_asserts
bind asaf_status asaf_status_asserts asaf_status_asserts_i (.*);

//--- testbench/asaf_status_test.sv
// self-checking bench for asaf_status with the host model
// assumes the checker is bound from its own file
module asaf_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK, SYS_RST, SPI_SELECT, FIFO_OVERFLOWED, FIFO_TRIGGERED, FIFO_SAMPLE_IN;
    logic ADDR_LOAD, READ_STROBE, BURST, STOP_SEEN, FIFO_INT_SOURCE, taken;
    logic [1:0] FIFO_MODE;
    logic [2:0] AXIS_ACQUIRED, HIGH_BYTE_READ;
    logic [5:0] FIFO_WATERMARK, FIFO_COUNT, c, w;
    logic [7:0] ADDR_VALUE, DATA_BYTE, READ_DATA, READ_ADDR, d, e;
    logic [7:0] q[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    asaf_status asaf_status_i (.*);
    asaf_host asaf_host_i (.*);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // acquisition pulse lasting one cycle
    task automatic acq(input logic [2:0] m);
        AXIS_ACQUIRED <= m;
        @(posedge CLOCK);
        AXIS_ACQUIRED <= 3'h0;
    endtask : acq
    initial
    begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // results land one edge after the strobe is taken
    always @(posedge CLOCK) taken <= READ_STROBE;
    always @(negedge CLOCK)
    begin
        if (taken)
            check(READ_DATA, q.pop_front());
    end
    // watchdog sized well above the run length
    initial
    begin
        repeat (3000) @(posedge CLOCK);
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        {SYS_RST, SPI_SELECT, FIFO_OVERFLOWED, FIFO_TRIGGERED, FIFO_SAMPLE_IN} = 5'h10;
        {FIFO_MODE, AXIS_ACQUIRED, HIGH_BYTE_READ, FIFO_WATERMARK, FIFO_COUNT} = 20'h0;
        DATA_BYTE = 8'h00;
        void'($urandom(32'h92387b51));
        repeat (10) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        @(posedge CLOCK);
        check({READ_DATA, READ_ADDR, FIFO_INT_SOURCE} === 17'h0 ? 8'h0 : 8'hff, 8'h00);
        // per axis: double acquire, read, then high-byte read clears all
        for (int i = 0; i < 3; i++)
        begin
            acq(3'h1 << i);
            @(posedge CLOCK);
            acq(3'h1 << i);
            q.push_back(8'h88 | (8'h11 << i));
            asaf_host_i.op(3'h2, 8'h00);
            HIGH_BYTE_READ <= 3'h1 << i;
            @(posedge CLOCK);
            HIGH_BYTE_READ <= 3'h0;
            q.push_back(8'h00);
            asaf_host_i.op(3'h2, 8'h00);
        end
        // mid-run reset drops flags raised just before it
        acq(3'h7);
        SYS_RST <= 1'b1;
        @(posedge CLOCK);
        SYS_RST <= 1'b0;
        @(posedge CLOCK);
        q.push_back(8'h00);
        asaf_host_i.op(3'h2, 8'h00);
        // burst: status then data byte, then stop handling per port
        d = 8'($urandom);
        DATA_BYTE <= d;
        q.push_back(8'h00);
        asaf_host_i.op(3'h2, 8'h01);
        q.push_back(d);
        asaf_host_i.op(3'h2, 8'h01);
        check(READ_ADDR, 8'h02);
        SPI_SELECT <= 1'b1;
        asaf_host_i.op(3'h1, 8'h00);
        check(READ_ADDR, 8'h02);
        SPI_SELECT <= 1'b0;
        asaf_host_i.op(3'h1, 8'h00);
        check(READ_ADDR, 8'h00);
        // loaded pointer, single read there keeps it, stop returns it to zero
        asaf_host_i.op(3'h4, 8'h01);
        q.push_back(d);
        asaf_host_i.op(3'h2, 8'h00);
        check(READ_ADDR, 8'h01);
        asaf_host_i.op(3'h1, 8'h00);
        check(READ_ADDR, 8'h00);
        // fifo status in randomly drawn nonzero modes with random levels
        repeat (12)
        begin
            c = 6'($urandom_range(32));
            w = 6'($urandom_range(32));
            FIFO_MODE <= 2'($urandom_range(3, 1));
            {FIFO_COUNT, FIFO_WATERMARK} <= {c, w};
            {FIFO_OVERFLOWED, FIFO_TRIGGERED} <= 2'($urandom);
            @(posedge CLOCK);
            e = {FIFO_OVERFLOWED, FIFO_MODE == 2'h3 ? FIFO_TRIGGERED : c >= w, c};
            q.push_back(e);
            asaf_host_i.op(3'h2, 8'h00);
        end
        // overflow plus new sample arms the source; a status read clears it
        {FIFO_OVERFLOWED, FIFO_SAMPLE_IN} <= 2'h3;
        @(posedge CLOCK);
        FIFO_SAMPLE_IN <= 1'b0;
        @(posedge CLOCK);
        check({7'h0, FIFO_INT_SOURCE}, 8'h01);
        q.push_back(e | 8'h80);
        asaf_host_i.op(3'h2, 8'h00);
        check({7'h0, FIFO_INT_SOURCE}, 8'h00);
        end_of_test();
    end
endmodule : asaf_status_test
